// *** shared/ssi_out_pkg.sv ***
// Constants, field layout and types of the SSI position word output block
package ssi_out_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int          CLK_PERIOD_NS   = 8;
    localparam int          MONO_TIME_NS    = 20000;
    localparam int          MONO_CYC        = (MONO_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [11:0] MONO_LAST       = 12'(MONO_CYC - 1);
    localparam logic [24:0] START_GUARD     = 25'h0000002;

    ////////////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int          POS_W           = 26;
    localparam int          TMR_W           = 24;
    localparam int          FRAC_W          = 10;
    localparam int          FRAC_SH         = 8;
    localparam logic [7:0]  FRAC_PAD        = 8'h00;
    localparam logic [5:0]  DIV_STEPS       = 6'h20;
    localparam logic [25:0] POS_MAX         = 26'h3ffffff;
    localparam logic [5:0]  LEN_24          = 6'h18;
    localparam logic [5:0]  LEN_25          = 6'h19;
    localparam logic [5:0]  LEN_26          = 6'h1a;
    localparam logic [5:0]  LEN_WORD        = 6'h20;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map and fields
    localparam logic [3:0]  REG_CTRL        = 4'h0;
    localparam logic [3:0]  REG_STATUS      = 4'h1;
    localparam logic [3:0]  REG_POS         = 4'h2;
    localparam logic [3:0]  REG_TEMP        = 4'h3;
    localparam int          CTRL_MODE_LSB   = 0;
    localparam int          CTRL_REV_BIT    = 2;
    localparam int          CTRL_GRAY_BIT   = 3;
    localparam int          CTRL_FMT_LSB    = 4;
    localparam int          CTRL_TEMP_BIT   = 6;
    localparam int          CTRL_DIFF_BIT   = 7;
    localparam int          CTRL_EXT_BIT    = 8;
    localparam int          CTRL_FILT_LSB   = 9;
    localparam int          CTRL_WIN_LSB    = 11;
    localparam int          CTRL_GRADE8_BIT = 13;
    localparam int          CTRL_MAGS_LSB   = 14;
    localparam logic [31:0] CTRL_RESET      = 32'h00004000;
    localparam int          ST_MAGS_LSB     = 0;
    localparam int          ST_ALARM_BIT    = 4;
    localparam int          ST_BUSY_BIT     = 5;

    ////////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {TM_ASYNC, TM_SYNC1, TM_SYNC2, TM_SYNC3} timing_t;
    typedef enum logic [1:0] {FMT_24, FMT_25, FMT_26, FMT_24AP} fmt_t;
    typedef enum logic [1:0] {FILT_NONE, FILT_FIR, FILT_IIR, FILT_OFF} filt_t;
    typedef enum logic [1:0] {SSI_IDLE, SSI_SHIFT, SSI_PAUSE} ssi_state_t;

endpackage : ssi_out_pkg

// *** shared/extrap_if.sv ***
// Request and answer of the extrapolation fraction divider
`timescale 1ns/100ps
`default_nettype none
interface extrap_if;
    logic [23:0] num;
    logic [23:0] den;
    logic [9:0]  quot;
    logic        done;
    modport calc (input num, input den, output quot, output done);
    modport user (output num, output den, input quot, input done);
endinterface : extrap_if
`default_nettype wire

// *** hw/frac_divider.sv ***
// Free-running serial divider: quot = min(num*256/den, 1023)
`timescale 1ns/100ps
`default_nettype none
module frac_divider (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic rst_in,
    // Operands and result
    extrap_if.calc    div
);
    logic [5:0]  step_q, step_d;
    logic [24:0] rem_q, rem_d, rem_sh;
    logic [31:0] dvd_q, dvd_d, quo_q, quo_d;
    logic [23:0] den_q, den_d;
    logic [9:0]  quot_q, quot_d;
    logic        done_q, done_d;

    ////////////////////////////////////////////////////////////////////////////////
    // One quotient bit per cycle, restarts on its own
    always_comb begin
        step_d = step_q;
        rem_d  = rem_q;
        dvd_d  = dvd_q;
        quo_d  = quo_q;
        den_d  = den_q;
        quot_d = quot_q;
        done_d = 1'b0;
        rem_sh = {rem_q[23:0], dvd_q[31]};
        if (step_q == 6'h00) begin
            dvd_d  = {div.num, ssi_out_pkg::FRAC_PAD};
            den_d  = div.den;
            rem_d  = '0;
            quo_d  = '0;
            step_d = 6'h01;
        end else begin
            if (rem_sh >= {1'b0, den_q}) begin
                rem_d = rem_sh - {1'b0, den_q};
                quo_d = {quo_q[30:0], 1'b1};
            end else begin
                rem_d = rem_sh;
                quo_d = {quo_q[30:0], 1'b0};
            end
            dvd_d = {dvd_q[30:0], 1'b0};
            if (step_q == ssi_out_pkg::DIV_STEPS) begin
                step_d = 6'h00;
                done_d = 1'b1;
                // Saturate: extrapolate at most four intervals ahead
                quot_d = (|quo_d[31:ssi_out_pkg::FRAC_W]) ? '1 : quo_d[9:0];
            end else begin
                step_d = step_q + 6'h01;
            end
        end
    end

    // Register stage
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            step_q <= '0;
            rem_q  <= '0;
            dvd_q  <= '0;
            quo_q  <= '0;
            den_q  <= '0;
            quot_q <= '0;
            done_q <= 1'b0;
        end else begin
            step_q <= step_d;
            rem_q  <= rem_d;
            dvd_q  <= dvd_d;
            quo_q  <= quo_d;
            den_q  <= den_d;
            quot_q <= quot_d;
            done_q <= done_d;
        end
    end

    assign div.quot = quot_q;
    assign div.done = done_q;
endmodule : frac_divider
`default_nettype wire

// *** hw/ssi_position_word_output.sv ***
// SSI position word output: filtering, extrapolation, word coding, shifter
`timescale 1ns/100ps
`default_nettype none
module ssi_position_word_output (
    // Clock and reset
    input  wire logic        REF_CLK_IN,
    input  wire logic        SYS_RST_IN,
    // SSI link
    input  wire logic        SSI_CLK_IN,
    output logic             SSI_DATA_OUT,
    // Measurement front end
    output logic             MEAS_START_OUT,
    input  wire logic        MEAS_DONE_IN,
    input  wire logic [25:0] POS_A_IN,
    input  wire logic [25:0] POS_B_IN,
    input  wire logic [3:0]  MAG_COUNT_IN,
    input  wire logic [7:0]  TEMP_IN,
    // Register port
    input  wire logic [3:0]  REG_ADDR_IN,
    input  wire logic [31:0] REG_WDATA_IN,
    input  wire logic        REG_WR_IN,
    input  wire logic        REG_RD_IN,
    output logic [31:0]      REG_RDATA_OUT
);
    ////////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [31:0]             ctrl_q, ctrl_d, rdata_q, rdata_d;
    ssi_out_pkg::timing_t    mode;
    ssi_out_pkg::fmt_t       fmt;
    ssi_out_pkg::filt_t      filt;
    logic                    rev, gray, temp_en, diff, ext_en, grade8;
    logic [1:0]              win;
    logic [3:0]              mags;
    logic                    busy_q, busy_d, start_q, start_d, started_q, started_d;
    logic [23:0]             dur_cnt_q, dur_cnt_d, dur_q, dur_d;
    logic [23:0]             since_q, since_d, period_q, period_d;
    logic [25:0]             hist_q [7], hist_d [7];
    logic [25:0]             iir_q, iir_d, p1_q, p1_d, p0_q, p0_d;
    logic [23:0]             elapsed_q, elapsed_d, interval_q, interval_d;
    logic                    fresh_q, fresh_d, alarm_q, alarm_d;
    logic [3:0]              seen_q, seen_d;
    logic [7:0]              temp_q, temp_d;
    logic [25:0]             diffv, rawsel, raw, fir, filtv;
    logic [28:0]             sum;
    logic [26:0]             err, step;
    logic [2:0]              nm1;
    logic                    can_sched;
    logic [25:0]             ext_q, ext_d;
    logic [26:0]             delta;
    logic [37:0]             prod, extsum;
    logic [24:0]             numsum;
    logic [2:0]              s_q, s_d;
    logic                    lvl_q, lvl_d, stable, rise, fall, latch;
    ssi_out_pkg::ssi_state_t st_q, st_d;
    logic [31:0]             sh_q, sh_d, word;
    logic [5:0]              left_q, left_d, len;
    logic [11:0]             quiet_q, quiet_d;
    logic                    data_q, data_d, use_ext, par;
    logic [25:0]             val;
    logic [23:0]             pos24;
    extrap_if                xif ();

    // Saturating timer increment
    function automatic logic [23:0] tinc(input logic [23:0] t);
        return (t == '1) ? t : t + 24'h000001;
    endfunction : tinc
    // Optional Gray coding of a zero-extended field
    function automatic logic [25:0] code(input logic [25:0] v, input logic g);
        return g ? (v ^ (v >> 1)) : v;
    endfunction : code
    // Configuration fields
    assign mode    = ssi_out_pkg::timing_t'(ctrl_q[ssi_out_pkg::CTRL_MODE_LSB +: 2]);
    assign fmt     = ssi_out_pkg::fmt_t'(ctrl_q[ssi_out_pkg::CTRL_FMT_LSB +: 2]);
    assign filt    = ssi_out_pkg::filt_t'(ctrl_q[ssi_out_pkg::CTRL_FILT_LSB +: 2]);
    assign win     = ctrl_q[ssi_out_pkg::CTRL_WIN_LSB +: 2];
    assign mags    = ctrl_q[ssi_out_pkg::CTRL_MAGS_LSB +: 4];
    assign rev     = ctrl_q[ssi_out_pkg::CTRL_REV_BIT];
    assign gray    = ctrl_q[ssi_out_pkg::CTRL_GRAY_BIT];
    assign temp_en = ctrl_q[ssi_out_pkg::CTRL_TEMP_BIT];
    assign diff    = ctrl_q[ssi_out_pkg::CTRL_DIFF_BIT];
    assign ext_en  = ctrl_q[ssi_out_pkg::CTRL_EXT_BIT];
    assign grade8  = ctrl_q[ssi_out_pkg::CTRL_GRADE8_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // Register port
    always_comb begin
        ctrl_d  = ctrl_q;
        rdata_d = '0;
        if (REG_WR_IN && REG_ADDR_IN == ssi_out_pkg::REG_CTRL) begin
            ctrl_d = REG_WDATA_IN;
        end
        if (REG_RD_IN) begin
            case (REG_ADDR_IN)
                ssi_out_pkg::REG_CTRL:   rdata_d = ctrl_q;
                ssi_out_pkg::REG_STATUS: begin
                    rdata_d[ssi_out_pkg::ST_MAGS_LSB +: 4]  = seen_q;
                    rdata_d[ssi_out_pkg::ST_ALARM_BIT]      = alarm_q;
                    rdata_d[ssi_out_pkg::ST_BUSY_BIT]       = (st_q != ssi_out_pkg::SSI_IDLE);
                end
                ssi_out_pkg::REG_POS:    rdata_d[25:0] = p1_q;
                ssi_out_pkg::REG_TEMP:   rdata_d[7:0]  = temp_q;
                default:                 rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            ctrl_q  <= ssi_out_pkg::CTRL_RESET;
            rdata_q <= '0;
        end else begin
            ctrl_q  <= ctrl_d;
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Raw sample, smoothing and measurement scheduling
    always_comb begin
        diffv  = (POS_B_IN >= POS_A_IN) ? POS_B_IN - POS_A_IN : POS_A_IN - POS_B_IN;
        rawsel = diff ? diffv : POS_A_IN;
        raw    = rev ? ssi_out_pkg::POS_MAX - rawsel : rawsel;
        // Window 2, 4 or 8: newest sample plus older history
        nm1    = (win == 2'h0) ? 3'h1 : (win == 2'h1) ? 3'h3 : 3'h7;
        sum    = {3'h0, raw};
        for (int i = 0; i < 7; i++) begin
            if (i < int'(nm1)) sum = sum + {3'h0, hist_q[i]};
        end
        fir    = (win == 2'h0) ? sum[26:1] : (win == 2'h1) ? sum[27:2] : sum[28:3];
        err    = $signed({1'b0, raw}) - $signed({1'b0, iir_q});
        step   = grade8 ? 27'($signed(err) >>> 3) : 27'($signed(err) >>> 2);
        iir_d  = iir_q;
        filtv  = raw;
        if (filt == ssi_out_pkg::FILT_FIR) filtv = fir;
        if (filt == ssi_out_pkg::FILT_IIR) filtv = 26'({1'b0, iir_q} + step);
        // Sync mode 1 starts once per request period, late enough
        can_sched = (mode != ssi_out_pkg::TM_SYNC1) || (period_q == '0)
                  || (!started_q && ({1'b0, since_q} + {1'b0, dur_q} + ssi_out_pkg::START_GUARD
                      >= {1'b0, period_q}));
        start_d    = !busy_q && !start_q && !MEAS_DONE_IN && can_sched;
        busy_d     = start_d ? 1'b1 : MEAS_DONE_IN ? 1'b0 : busy_q;
        dur_cnt_d  = start_d ? '0 : busy_q ? tinc(dur_cnt_q) : dur_cnt_q;
        dur_d      = dur_q;
        started_d  = start_d ? 1'b1 : latch ? 1'b0 : started_q;
        since_d    = latch ? '0 : tinc(since_q);
        period_d   = latch ? since_q : period_q;
        hist_d     = hist_q;
        p1_d       = p1_q;
        p0_d       = p0_q;
        elapsed_d  = tinc(elapsed_q);
        interval_d = interval_q;
        fresh_d    = latch ? 1'b0 : fresh_q;
        alarm_d    = alarm_q;
        seen_d     = seen_q;
        temp_d     = temp_q;
        if (MEAS_DONE_IN) begin
            hist_d[0] = raw;
            for (int i = 1; i < 7; i++) hist_d[i] = hist_q[i-1];
            iir_d      = filtv;
            dur_d      = dur_cnt_q;
            p0_d       = p1_q;
            p1_d       = filtv;
            interval_d = elapsed_q;
            elapsed_d  = '0;
            fresh_d    = 1'b1;
            alarm_d    = (MAG_COUNT_IN != mags);
            seen_d     = MAG_COUNT_IN;
            temp_d     = TEMP_IN;
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            busy_q <= 1'b0;
            start_q <= 1'b0;
            started_q <= 1'b0;
            dur_cnt_q <= '0;
            dur_q <= '0;
            since_q <= '0;
            period_q <= '0;
            for (int i = 0; i < 7; i++) hist_q[i] <= '0;
            iir_q <= '0;
            p1_q <= '0;
            p0_q <= '0;
            elapsed_q <= '0;
            interval_q <= '0;
            fresh_q <= 1'b0;
            alarm_q <= 1'b0;
            seen_q <= '0;
            temp_q <= '0;
        end else begin
            busy_q <= busy_d;
            start_q <= start_d;
            started_q <= started_d;
            dur_cnt_q <= dur_cnt_d;
            dur_q <= dur_d;
            since_q <= since_d;
            period_q <= period_d;
            hist_q <= hist_d;
            iir_q <= iir_d;
            p1_q <= p1_d;
            p0_q <= p0_d;
            elapsed_q <= elapsed_d;
            interval_q <= interval_d;
            fresh_q <= fresh_d;
            alarm_q <= alarm_d;
            seen_q <= seen_d;
            temp_q <= temp_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Linear extrapolation; mode 3 adds the measurement lag
    assign numsum = {1'b0, elapsed_q} + ((mode == ssi_out_pkg::TM_SYNC3) ? {1'b0, dur_q} : '0);
    assign xif.num = numsum[24] ? '1 : numsum[23:0];
    assign xif.den = interval_q;
    frac_divider u_div (
        .clk_in (REF_CLK_IN),
        .rst_in (SYS_RST_IN),
        .div    (xif)
    );
    // Full-width product: slope times fraction must not wrap
    always_comb begin
        delta  = $signed({1'b0, p1_q}) - $signed({1'b0, p0_q});
        prod   = $signed({{11{delta[26]}}, delta}) * $signed({28'h0, xif.quot});
        extsum = 38'($signed({12'h000, p1_q}) + ($signed(prod) >>> ssi_out_pkg::FRAC_SH));
        ext_d  = ext_q;
        if (xif.done) begin
            if (interval_q == '0 || extsum[37]) ext_d = (interval_q == '0) ? p1_q : '0;
            else if (|extsum[36:26]) ext_d = ssi_out_pkg::POS_MAX;
            else ext_d = extsum[25:0];
        end
    end
    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) ext_q <= '0;
        else ext_q <= ext_d;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Output word selection and coding
    always_comb begin
        use_ext = (mode == ssi_out_pkg::TM_SYNC3)
               || (((mode == ssi_out_pkg::TM_SYNC2)
                   || (mode == ssi_out_pkg::TM_ASYNC && ext_en)) && !fresh_q);
        val     = use_ext ? ext_q : p1_q;
        pos24   = 24'(code({2'h0, val[23:0]}, gray));
        par     = ^{pos24, alarm_q};
        word    = '0;
        len     = ssi_out_pkg::LEN_24;
        if (temp_en) begin
            word = {8'(code({18'h0, temp_q}, gray)), pos24};
            len  = ssi_out_pkg::LEN_WORD;
        end else begin
            unique case (fmt)
                ssi_out_pkg::FMT_24:   word[23:0] = pos24;
                ssi_out_pkg::FMT_25: begin
                    word[24:0] = 25'(code({1'h0, val[24:0]}, gray));
                    len        = ssi_out_pkg::LEN_25;
                end
                ssi_out_pkg::FMT_26: begin
                    word[25:0] = code(val, gray);
                    len        = ssi_out_pkg::LEN_26;
                end
                ssi_out_pkg::FMT_24AP: begin
                    word[25:0] = {pos24, alarm_q, par};
                    len        = ssi_out_pkg::LEN_26;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // SSI clock sampling and shift machine
    always_comb begin
        s_d    = {s_q[1:0], SSI_CLK_IN};
        stable = (s_q[1] == s_q[2]);
        rise   = stable && s_q[2] && !lvl_q;
        fall   = stable && !s_q[2] && lvl_q;
        lvl_d  = stable ? s_q[2] : lvl_q;
        latch  = (st_q == ssi_out_pkg::SSI_IDLE) && fall;
        st_d    = st_q;
        sh_d    = sh_q;
        left_d  = left_q;
        data_d  = data_q;
        quiet_d = (rise || fall) ? '0 : quiet_q + 12'h001;
        unique case (st_q)
            ssi_out_pkg::SSI_IDLE: begin
                quiet_d = '0;
                data_d  = 1'b1;
                if (latch) begin
                    sh_d   = word << (ssi_out_pkg::LEN_WORD - len);
                    left_d = len;
                    st_d   = ssi_out_pkg::SSI_SHIFT;
                end
            end
            ssi_out_pkg::SSI_SHIFT: begin
                if (rise) begin
                    data_d = sh_q[31];
                    sh_d   = {sh_q[30:0], 1'b0};
                    left_d = left_q - 6'h01;
                    if (left_q == 6'h01) st_d = ssi_out_pkg::SSI_PAUSE;
                end
            end
            ssi_out_pkg::SSI_PAUSE: if (rise) data_d = 1'b0;
            default: st_d = ssi_out_pkg::SSI_IDLE;
        endcase
        // Clock gone quiet: a cut frame or a finished one ends here
        if (st_q != ssi_out_pkg::SSI_IDLE && quiet_q == ssi_out_pkg::MONO_LAST) begin
            st_d   = ssi_out_pkg::SSI_IDLE;
            data_d = 1'b1;
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            s_q     <= 3'h7;
            lvl_q   <= 1'b1;
            st_q    <= ssi_out_pkg::SSI_IDLE;
            sh_q    <= '0;
            left_q  <= '0;
            quiet_q <= '0;
            data_q  <= 1'b1;
        end else begin
            s_q     <= s_d;
            lvl_q   <= lvl_d;
            st_q    <= st_d;
            sh_q    <= sh_d;
            left_q  <= left_d;
            quiet_q <= quiet_d;
            data_q  <= data_d;
        end
    end
    // Outputs straight from flip-flops
    assign SSI_DATA_OUT   = data_q;
    assign MEAS_START_OUT = start_q;
    assign REG_RDATA_OUT  = rdata_q;
endmodule : ssi_position_word_output
`default_nettype wire

// *** bench/ssi_word_checker_assertions.sv ***
// Checker of SSI word timing and register port behaviour
`timescale 1ns/100ps
`default_nettype none
module ssi_word_checker (
    // Watched ports
    input wire logic        REF_CLK_IN,
    input wire logic        SYS_RST_IN,
    input wire logic        SSI_CLK_IN,
    input wire logic        SSI_DATA_OUT,
    input wire logic        MEAS_START_OUT,
    input wire logic        MEAS_DONE_IN,
    input wire logic        REG_RD_IN,
    input wire logic [3:0]  REG_ADDR_IN,
    input wire logic [31:0] REG_RDATA_OUT
);
    logic [11:0] gap_q;
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    ////////////////////////////////////////////////
    // Cycles since the last link clock rise
    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) gap_q <= 12'hfff;
        else if ($rose(SSI_CLK_IN)) gap_q <= 12'h000;
        else if (gap_q != 12'hfff) gap_q <= gap_q + 12'h001;
    end
    // Bit launch: a rise then a data change a few cycles later
    sequence rise_seen;
        gap_q < 12'h008;
    endsequence
    a_reset_idle: assert property (disable iff (1'b0)
        SYS_RST_IN |=> SSI_DATA_OUT && !MEAS_START_OUT && REG_RDATA_OUT == 32'h0)
        else $error("outputs not idle after reset");
    a_start_pulse: assert property (MEAS_START_OUT |=> !MEAS_START_OUT)
        else $error("start longer than one cycle");
    a_done_gap: assert property (MEAS_DONE_IN |=> !MEAS_START_OUT)
        else $error("start right after done");
    a_rdata_idle: assert property (!REG_RD_IN |=> REG_RDATA_OUT == 32'h0)
        else $error("read data without read");
    a_unmapped_zero: assert property (REG_RD_IN && REG_ADDR_IN > 4'h3 |=>
        REG_RDATA_OUT == 32'h0) else $error("unmapped read not zero");
    a_data_hold: assert property (gap_q inside {[12'h008:12'h960]} |->
        $stable(SSI_DATA_OUT)) else $error("data moved between clock edges");
    a_fall_cause: assert property ($fell(SSI_DATA_OUT) |-> rise_seen)
        else $error("data fell without clock rise");
    a_quiet_idle: assert property (gap_q == 12'h9d8 |-> SSI_DATA_OUT)
        else $error("data not idle after quiet time");
endmodule : ssi_word_checker
`default_nettype wire

// *** bench/ssi_master_model.sv ***
// Controller model: drives the SSI clock and gathers one word
`timescale 1ns/100ps
`default_nettype none
module ssi_master_model (
    // Link pins
    output var logic sclk_out,
    input  wire logic data_in
);
    ////////////////////////////////////////////////
    // Clock idles high between frames
    initial sclk_out = 1'b1;
    // First fall latches, each later rise samples the previous bit
    task automatic read_word(input int len, output logic [31:0] w);
        w = 32'h0;
        #3;
        for (int i = 0; i <= len; i++) begin
            #32 sclk_out = 1'b0;
            #32 sclk_out = 1'b1;
            if (i > 0) w = {w[30:0], data_in};
        end
        #22000;
    endtask : read_word
endmodule : ssi_master_model
`default_nettype wire

// *** bench/ssi_position_word_output_tb.sv ***
// Testbench of the SSI position word output block
`timescale 1ns/100ps
`default_nettype none
module ssi_position_word_output_tb;
    typedef struct {logic [31:0] c; logic [25:0] a, b; logic [3:0] m; int n; logic [31:0] x;} row_t;
    logic        clk = 1'b0, rst = 1'b1, sclk, sdata, m_start, m_done = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [3:0]  addr = 4'h0, mags = 4'h1;
    logic [25:0] pa = 26'h0, pb = 26'h0;
    logic [31:0] wdata = 32'h0, rdata, w;
    int          n_mismatch = 0, cmp_count = 0, cyc = 0;
    row_t        rows [15] = '{
        '{32'h4000, 26'h123456, 26'h0, 4'h1, 24, 32'h123456},
        '{32'h4001, 26'h123456, 26'h0, 4'h1, 24, 32'h123456},
        '{32'h4002, 26'h123456, 26'h0, 4'h1, 24, 32'h123456},
        '{32'h4003, 26'h123456, 26'h0, 4'h1, 24, 32'h123456},
        '{32'h4100, 26'h123456, 26'h0, 4'h1, 24, 32'h123456},
        '{32'h4008, 26'h123456, 26'h0, 4'h1, 24, 32'h1b2e7d},
        '{32'h4030, 26'h123456, 26'h0, 4'h2, 26, 32'h48d15a},
        '{32'h4040, 26'h123456, 26'h0, 4'h1, 32, 32'h5a123456},
        '{32'h4048, 26'h123456, 26'h0, 4'h1, 32, 32'h771b2e7d},
        '{32'h5200, 26'h123456, 26'h0, 4'h1, 24, 32'h123456},
        '{32'h4010, 26'h1abcdef, 26'h0, 4'h1, 25, 32'h1abcdef},
        '{32'h4020, 26'h3abcdef, 26'h0, 4'h1, 26, 32'h3abcdef},
        '{32'h4024, 26'h100, 26'h0, 4'h1, 26, 32'h3fffeff},
        '{32'h4080, 26'h100000, 26'h0ff000, 4'h1, 24, 32'h1000},
        '{32'h4400, 26'h1100, 26'h0, 4'h1, 24, 32'h10fd}};
    ////////////////////////////////////////////////
    ssi_position_word_output dut (.REF_CLK_IN(clk), .SYS_RST_IN(rst), .SSI_CLK_IN(sclk),
        .SSI_DATA_OUT(sdata), .MEAS_START_OUT(m_start), .MEAS_DONE_IN(m_done), .POS_A_IN(pa),
        .POS_B_IN(pb), .MAG_COUNT_IN(mags), .TEMP_IN(8'h5a), .REG_ADDR_IN(addr),
        .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata));
    ssi_master_model host (.sclk_out(sclk), .data_in(sdata));
    // Clock, front end answering each start, hang limit
    always #4 clk = ~clk;
    always @(posedge clk) m_done <= m_start;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_mismatch++;
            close_out();
        end
    end
    // Compare, register cycle, verdict
    task automatic chk(input string what, input logic [31:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask : chk
    task automatic reg_op(input logic we, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= we;
        rd <= !we;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 w = rdata;
    endtask : reg_op
    task automatic close_out();
        if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : close_out
    // Refused write and unmapped read, then table of words, then a second reset
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        reg_op(1'b1, 4'h2, 32'hffff);
        reg_op(1'b0, 4'h0, 32'h0);
        chk("ctrl", w, 32'h4000);
        reg_op(1'b0, 4'hf, 32'h0);
        chk("unmapped", w, 32'h0);
        foreach (rows[i]) begin
            reg_op(1'b1, 4'h0, rows[i].c);
            pa <= rows[i].a;
            pb <= rows[i].b;
            mags <= rows[i].m;
            repeat (60) @(posedge clk);
            host.read_word(rows[i].n, w);
            chk("word", w, rows[i].x);
            reg_op(1'b0, 4'h1, 32'h0);
            chk("alarm", {31'h0, w[4]}, {31'h0, rows[i].m != 4'h1});
        end
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        reg_op(1'b0, 4'h0, 32'h0);
        chk("ctrl", w, 32'h4000);
        close_out();
    end
endmodule : ssi_position_word_output_tb
bind ssi_position_word_output ssi_word_checker u_chk (.REF_CLK_IN(REF_CLK_IN),
    .SYS_RST_IN(SYS_RST_IN), .SSI_CLK_IN(SSI_CLK_IN), .SSI_DATA_OUT(SSI_DATA_OUT),
    .MEAS_START_OUT(MEAS_START_OUT), .MEAS_DONE_IN(MEAS_DONE_IN), .REG_RD_IN(REG_RD_IN),
    .REG_ADDR_IN(REG_ADDR_IN), .REG_RDATA_OUT(REG_RDATA_OUT));
`default_nettype wire
